// file: logic/pdmmic_top.sv
`timescale 1ns/1ps
`include "pdmmic_defines.svh"
module pdmmic_top #(
  parameter int SAMPLE_W = `PDMMIC_SAMPLE_W,
  parameter int FIFO_DEPTH = `PDMMIC_FIFO_DEPTH,
  parameter int SLEEP_CYC = `PDMMIC_SLEEP_CYC,
  parameter int SETTLE_CYC = `PDMMIC_SETTLE_CYC
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic PDM_CLK_I,
  input wire logic SLOT_SEL_I,
  input wire logic [SAMPLE_W-1:0] AUDIO_DATA_I,
  input wire logic AUDIO_VALID_I,
  output logic AUDIO_READY_O,
  output logic PDM_DATA_O,
  output logic PDM_DATA_OE_O,
  output pdmmic_pkg::pdmmic_mode_t MODE_O,
  output logic SETTLED_O,
  output logic LEFT_SLOT_O
);
  // accumulators carry guard bits above the sample width
  localparam int ACC_W = SAMPLE_W + `PDMMIC_ACC_GUARD;
  localparam int ORDER = `PDMMIC_MOD_ORDER;
  localparam int SLP_W = $clog2(SLEEP_CYC);
  localparam int SET_W = $clog2(SETTLE_CYC);
  localparam logic [SLP_W-1:0] SLEEP_LAST = SLP_W'(SLEEP_CYC - 1);
  localparam logic [SET_W-1:0] SETTLE_LAST = SET_W'(SETTLE_CYC - 1);
  localparam logic [`PDMMIC_PER_W-1:0] SLEEP_PER = `PDMMIC_PER_W'(`PDMMIC_SLEEP_PER);
  localparam logic [`PDMMIC_PER_W-1:0] LP_PER = `PDMMIC_PER_W'(`PDMMIC_LP_PER);
  localparam logic [`PDMMIC_PER_W-1:0] HQ_PER = `PDMMIC_PER_W'(`PDMMIC_HQ_PER);
  localparam logic [`PDMMIC_PER_W-1:0] PER_SAT = `PDMMIC_PER_W'(`PDMMIC_SLEEP_PER + 1);
  // feedback levels equal the sample full scale
  localparam logic signed [ACC_W-1:0] FB_POS = ACC_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
  localparam logic signed [ACC_W-1:0] FB_NEG = -FB_POS;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic link_sync1_reg; // first stage, host clock
  logic link_sync2_reg; // second stage, host clock
  logic link_prev_reg; // delayed copy for edge finding
  logic link_rise; // host clock rising edge seen
  logic link_fall; // host clock falling edge seen
  logic sel_sync1_reg; // first stage, strap
  logic sel_sync2_reg; // second stage, strap
  logic [1:0] strap_wait_reg; // lets the strap synchroniser fill
  logic strap_done_reg; // strap captured
  logic strap_left_reg; // high selects the left slot
  logic [`PDMMIC_PER_W-1:0] per_cnt_reg; // cycles since last rise
  logic [`PDMMIC_PER_W-1:0] period_reg; // last measured period
  logic per_slow; // clock too slow or stopped
  pdmmic_pkg::pdmmic_band_t band; // measured band
  pdmmic_pkg::pdmmic_mode_t mode_reg; // current mode
  pdmmic_pkg::pdmmic_mode_t mode_next;
  logic [SLP_W-1:0] sleep_cnt_reg; // time spent in sleep band
  logic [SLP_W-1:0] sleep_cnt_next;
  logic [SET_W-1:0] settle_cnt_reg; // time since last mode change
  logic [SET_W-1:0] settle_cnt_next;
  logic settled_reg; // output has settled
  logic settled_next;
  logic mode_change; // mode moves this cycle
  logic can_drive; // allowed to use the line
  logic slot_start; // own half period begins
  logic slot_stop; // own half period ends
  logic oe_reg; // line driven
  logic oe_next;
  logic data_reg; // bit on the line
  logic data_next;
  logic step; // modulator advances one bit
  logic [SAMPLE_W-1:0] fifo_data; // head of the sample queue
  logic fifo_valid; // queue holds a sample
  logic signed [SAMPLE_W-1:0] x_reg; // sample being modulated
  logic signed [ACC_W-1:0] acc_reg [ORDER]; // integrator chain
  logic signed [ACC_W-1:0] acc_next [ORDER];
  logic signed [ACC_W-1:0] fb; // quantiser feedback level
  logic mod_bit; // quantiser output

  ////////////////////////////////////////////////////////////////////////////
  // saturating integrator step, shared by every stage
  function automatic logic signed [ACC_W-1:0] integ(input logic signed [ACC_W-1:0] acc,
                                                    input logic signed [ACC_W-1:0] in_v,
                                                    input logic signed [ACC_W-1:0] fb_v);
    logic signed [ACC_W+1:0] sum;
    logic [2:0] top;
    sum = (ACC_W+2)'(acc) + (((ACC_W+2)'(in_v) - (ACC_W+2)'(fb_v)) >>> `PDMMIC_MOD_SHIFT);
    top = sum[ACC_W+1:ACC_W-1];
    // clamping keeps a high order loop from wrapping into a limit cycle
    if (top == 3'h0 || top == 3'h7) begin
      integ = sum[ACC_W-1:0];
    end else if (sum[ACC_W+1]) begin
      integ = {1'b1, {(ACC_W-1){1'b0}}};
    end else begin
      integ = {1'b0, {(ACC_W-1){1'b1}}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage is looked at
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      link_sync1_reg <= 1'b0;
      link_sync2_reg <= 1'b0;
      link_prev_reg <= 1'b0;
      sel_sync1_reg <= 1'b0;
      sel_sync2_reg <= 1'b0;
    end else begin
      link_sync1_reg <= PDM_CLK_I;
      link_sync2_reg <= link_sync1_reg;
      link_prev_reg <= link_sync2_reg;
      sel_sync1_reg <= SLOT_SEL_I;
      sel_sync2_reg <= sel_sync1_reg;
    end
  end

  // edges of the host clock
  assign link_rise = link_sync2_reg && !link_prev_reg;
  assign link_fall = !link_sync2_reg && link_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture, once after reset release
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      strap_wait_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_left_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
      if (strap_wait_reg == `PDMMIC_STRAP_WAIT) begin
        strap_done_reg <= 1'b1;
        strap_left_reg <= sel_sync2_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // period measurement, rise to rise
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      per_cnt_reg <= PER_SAT;
      period_reg <= PER_SAT;
    end else if (link_rise) begin
      period_reg <= per_cnt_reg;
      per_cnt_reg <= `PDMMIC_PER_W'(1);
    end else if (per_cnt_reg != PER_SAT) begin
      per_cnt_reg <= per_cnt_reg + `PDMMIC_PER_W'(1);
    end
  end

  // band; between 200 and 400 kHz no band, mode holds
  assign per_slow = (per_cnt_reg > SLEEP_PER) || (period_reg > SLEEP_PER);
  assign band = per_slow ? pdmmic_pkg::PDMMIC_BAND_SLEEP :
                (period_reg <= HQ_PER) ? pdmmic_pkg::PDMMIC_BAND_HQ :
                (period_reg <= LP_PER) ? pdmmic_pkg::PDMMIC_BAND_LP :
                pdmmic_pkg::PDMMIC_BAND_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine
  always_comb begin
    mode_next = mode_reg;
    sleep_cnt_next = '0;
    case (mode_reg)
      pdmmic_pkg::PDMMIC_MODE_SLEEP: begin
        if (band == pdmmic_pkg::PDMMIC_BAND_HQ) begin
          mode_next = pdmmic_pkg::PDMMIC_MODE_HQ;
        end else if (band == pdmmic_pkg::PDMMIC_BAND_LP) begin
          mode_next = pdmmic_pkg::PDMMIC_MODE_LP;
        end
      end
      pdmmic_pkg::PDMMIC_MODE_LP, pdmmic_pkg::PDMMIC_MODE_HQ: begin
        if (band == pdmmic_pkg::PDMMIC_BAND_SLEEP) begin
          // slow clock must persist for the whole sleep time
          sleep_cnt_next = sleep_cnt_reg + SLP_W'(1);
          if (sleep_cnt_reg == SLEEP_LAST) begin
            mode_next = pdmmic_pkg::PDMMIC_MODE_SLEEP;
            sleep_cnt_next = '0;
          end
        end else if (band == pdmmic_pkg::PDMMIC_BAND_HQ) begin
          mode_next = pdmmic_pkg::PDMMIC_MODE_HQ;
        end else if (band == pdmmic_pkg::PDMMIC_BAND_LP) begin
          mode_next = pdmmic_pkg::PDMMIC_MODE_LP;
        end
      end
      default: begin
        mode_next = pdmmic_pkg::PDMMIC_MODE_SLEEP;
      end
    endcase
  end

  // settling timer restarts at every mode change
  assign mode_change = (mode_next != mode_reg);
  assign settle_cnt_next = (mode_change || mode_reg == pdmmic_pkg::PDMMIC_MODE_SLEEP) ? '0 :
                           (settle_cnt_reg == SETTLE_LAST) ? settle_cnt_reg :
                           settle_cnt_reg + SET_W'(1);
  assign settled_next = !mode_change && (mode_reg != pdmmic_pkg::PDMMIC_MODE_SLEEP) &&
                        (settle_cnt_reg == SETTLE_LAST);

  // mode registers
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mode_reg <= pdmmic_pkg::PDMMIC_MODE_SLEEP;
      sleep_cnt_reg <= '0;
      settle_cnt_reg <= '0;
      settled_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      sleep_cnt_reg <= sleep_cnt_next;
      settle_cnt_reg <= settle_cnt_next;
      settled_reg <= settled_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample queue; asleep nothing pops, so it stalls the source once full
  pdmmic_fifo #(
    .W(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .in_data_i(AUDIO_DATA_I),
    .in_valid_i(AUDIO_VALID_I),
    .in_ready_o(AUDIO_READY_O),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(step)
  );

  ////////////////////////////////////////////////////////////////////////////
  // slot timing; right slot opens on fall, left on rise
  assign can_drive = strap_done_reg && (mode_reg != pdmmic_pkg::PDMMIC_MODE_SLEEP);
  assign slot_start = strap_left_reg ? link_rise : link_fall;
  assign slot_stop = strap_left_reg ? link_fall : link_rise;
  assign step = can_drive && slot_start;

  // line driver; sync latency already exceeds the least enable delay
  always_comb begin
    oe_next = oe_reg;
    data_next = data_reg;
    if (!can_drive || slot_stop) begin
      oe_next = 1'b0;
    end else if (slot_start) begin
      oe_next = 1'b1;
      data_next = mod_bit;
    end
  end

  // driver registers
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      oe_reg <= 1'b0;
      data_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
      data_reg <= data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modulator; positive feedback for a one, so full scale gives all ones
  assign mod_bit = !acc_reg[ORDER-1][ACC_W-1];
  assign fb = mod_bit ? FB_POS : FB_NEG;

  // integrator chain
  always_comb begin
    acc_next[0] = integ(acc_reg[0], ACC_W'(x_reg), fb);
    for (int k = 1; k < ORDER; k++) begin
      acc_next[k] = integ(acc_reg[k], acc_reg[k-1], fb);
    end
  end

  // modulator state; an empty queue repeats the last sample
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      x_reg <= '0;
      for (int k = 0; k < ORDER; k++) begin
        acc_reg[k] <= '0;
      end
    end else if (step) begin
      if (fifo_valid) begin
        x_reg <= fifo_data;
      end
      for (int k = 0; k < ORDER; k++) begin
        acc_reg[k] <= acc_next[k];
      end
    end
  end

  // outputs straight from registers
  assign PDM_DATA_O = data_reg;
  assign PDM_DATA_OE_O = oe_reg;
  assign MODE_O = mode_reg;
  assign SETTLED_O = settled_reg;
  assign LEFT_SLOT_O = strap_left_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  sleep_entry_a: assert property (
    mode_reg != pdmmic_pkg::PDMMIC_MODE_SLEEP && band == pdmmic_pkg::PDMMIC_BAND_SLEEP &&
    sleep_cnt_reg == SLEEP_LAST |=> mode_reg == pdmmic_pkg::PDMMIC_MODE_SLEEP ##1 !PDM_DATA_OE_O)
    else $error("sleep not entered after sleep time");
  wake_quality_a: assert property (
    mode_reg == pdmmic_pkg::PDMMIC_MODE_SLEEP && band == pdmmic_pkg::PDMMIC_BAND_HQ
    |=> mode_reg == pdmmic_pkg::PDMMIC_MODE_HQ && !SETTLED_O)
    else $error("wake to quality mode wrong");
  wake_lowpower_a: assert property (
    mode_reg == pdmmic_pkg::PDMMIC_MODE_SLEEP && band == pdmmic_pkg::PDMMIC_BAND_LP
    |=> mode_reg == pdmmic_pkg::PDMMIC_MODE_LP && !SETTLED_O)
    else $error("wake to low-power mode wrong");
  settle_time_a: assert property (
    $rose(SETTLED_O) |-> $past(settle_cnt_reg) == SETTLE_LAST && $stable(mode_reg))
    else $error("settled raised before settling time");
  band_mode_a: assert property (
    $changed(mode_reg) && mode_reg == pdmmic_pkg::PDMMIC_MODE_HQ |-> $past(band) == pdmmic_pkg::PDMMIC_BAND_HQ)
    else $error("quality mode without quality band");
  drive_start_a: assert property (
    step && !slot_stop |=> PDM_DATA_OE_O ##1 (PDM_DATA_OE_O || $past(slot_stop) || !$past(can_drive)))
    else $error("line not driven at slot start");
  release_line_a: assert property (
    oe_reg && slot_stop |=> !PDM_DATA_OE_O)
    else $error("line not released at slot end");
  sleep_quiet_a: assert property (
    mode_reg == pdmmic_pkg::PDMMIC_MODE_SLEEP |=> !PDM_DATA_OE_O)
    else $error("line driven while asleep");
  slot_bit_a: assert property (
    $rose(PDM_DATA_OE_O) |-> PDM_DATA_O == $past(mod_bit) && $past(slot_start))
    else $error("slot bit not from modulator");
  strap_hold_a: assert property (
    strap_done_reg |=> strap_done_reg && $stable(LEFT_SLOT_O))
    else $error("strap changed after capture");
endmodule

// file: shared/pdmmic_defines.svh
`ifndef PDMMIC_DEFINES_SVH
`define PDMMIC_DEFINES_SVH

// system clock rate
`define PDMMIC_CLK_KHZ 25000
// band edges of the host clock
`define PDMMIC_SLEEP_KHZ 200
`define PDMMIC_LP_KHZ 400
`define PDMMIC_HQ_KHZ 1200
// settling and sleep entry times
`define PDMMIC_SLEEP_TIME_US 1000
`define PDMMIC_SETTLE_TIME_US 7000
// least delay from clock edge to driving the line
`define PDMMIC_OUT_EN_NS 30
`define PDMMIC_OUT_EN_CYC ((`PDMMIC_OUT_EN_NS * `PDMMIC_CLK_KHZ + 999999) / 1000000)
// host clock period limits, in system cycles
`define PDMMIC_SLEEP_PER (`PDMMIC_CLK_KHZ / `PDMMIC_SLEEP_KHZ)
`define PDMMIC_LP_PER (`PDMMIC_CLK_KHZ / `PDMMIC_LP_KHZ)
`define PDMMIC_HQ_PER (`PDMMIC_CLK_KHZ / `PDMMIC_HQ_KHZ)
`define PDMMIC_PER_W 8
// long counts, in system cycles
`define PDMMIC_SLEEP_CYC (`PDMMIC_SLEEP_TIME_US * `PDMMIC_CLK_KHZ / 1000)
`define PDMMIC_SETTLE_CYC (`PDMMIC_SETTLE_TIME_US * `PDMMIC_CLK_KHZ / 1000)
// data path shape
`define PDMMIC_SAMPLE_W 16
`define PDMMIC_FIFO_DEPTH 8
`define PDMMIC_MOD_ORDER 4
`define PDMMIC_MOD_SHIFT 2
`define PDMMIC_ACC_GUARD 4
// cycles the strap synchroniser needs before capture
`define PDMMIC_STRAP_WAIT 2'h2

`endif

// file: shared/pdmmic_pkg.sv
package pdmmic_pkg;

  // operating mode of the microphone
  typedef enum logic [1:0] {
    PDMMIC_MODE_SLEEP,
    PDMMIC_MODE_LP,
    PDMMIC_MODE_HQ
  } pdmmic_mode_t;

  // band the measured host clock falls in
  typedef enum logic [1:0] {
    PDMMIC_BAND_SLEEP,
    PDMMIC_BAND_LP,
    PDMMIC_BAND_HQ,
    PDMMIC_BAND_NONE
  } pdmmic_band_t;

endpackage

// file: logic/pdmmic_fifo.sv
`timescale 1ns/1ps
module pdmmic_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  // depth must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH]; // storage words
  logic [AW:0] wr_ptr_reg; // write pointer, extra wrap bit
  logic [AW:0] rd_ptr_reg; // read pointer, extra wrap bit
  logic full; // all words in use
  logic empty; // nothing stored
  logic push; // word accepted
  logic pop; // word handed out

  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  // storage write, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  // pointer update
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
      end
    end
  end
endmodule

// file: dv/pdmmic_host.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// host receiver model: makes the pdm clock, samples the shared line
module pdmmic_host (
  input wire logic run_i,
  input wire logic [15:0] half_ns_i,
  input wire logic left_i,
  input wire logic data_i,
  input wire logic oe_i,
  input wire logic clr_i,
  output logic pdm_clk_o,
  output logic [15:0] bits_o,
  output logic [15:0] ones_o,
  output logic [15:0] idle_o
);
  logic last_reg = 1'b0; // last level the device drove
  // no pull on the line: an idle line shows the inverse, never a stale good bit
  wire line = oe_i ? data_i : ~last_reg;
  always @(data_i or oe_i) begin
    if (oe_i) last_reg = data_i;
  end
  ////////////////////////////////////////////////////////////
  // clock stands low between frames, even duty while running
  always begin
    if (run_i) begin
      #(half_ns_i) pdm_clk_o = ~pdm_clk_o;
    end else begin
      pdm_clk_o = 1'b0;
      wait (run_i);
    end
  end
  ////////////////////////////////////////////////////////////
  // left captured on fall, right on rise
  always @(pdm_clk_o or posedge clr_i) begin
    if (clr_i) begin
      bits_o = 16'h0000;
      ones_o = 16'h0000;
      idle_o = 16'h0000;
    end else if (pdm_clk_o != left_i) begin
      bits_o = bits_o + 16'h0001;
      ones_o = ones_o + {15'h0000, line};
      idle_o = idle_o + {15'h0000, ~oe_i};
    end
  end
endmodule

// file: dv/pdmmic_top_tb.sv
`timescale 1ns/1ps
module pdmmic_top_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sel = 1'b0; // channel strap
  logic [15:0] adata = 16'h0000;
  logic avalid = 1'b0;
  logic run = 1'b0; // host clock running
  logic clr = 1'b0;
  logic [15:0] half_ns = 16'h00A0; // 320 ns period
  wire pdm_clk, ready, pdata, oe, settled, left;
  pdmmic_pkg::pdmmic_mode_t mode;
  wire [15:0] bits, ones, idle;
  int mismatches = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  // short counts so the run stays brief
  pdmmic_top #(.SLEEP_CYC(64), .SETTLE_CYC(200)) uut (
    .CLK_I(clk), .SRST_I(srst), .PDM_CLK_I(pdm_clk), .SLOT_SEL_I(sel),
    .AUDIO_DATA_I(adata), .AUDIO_VALID_I(avalid), .AUDIO_READY_O(ready),
    .PDM_DATA_O(pdata), .PDM_DATA_OE_O(oe), .MODE_O(mode),
    .SETTLED_O(settled), .LEFT_SLOT_O(left));
  pdmmic_host host (
    .run_i(run), .half_ns_i(half_ns), .left_i(sel), .data_i(pdata),
    .oe_i(oe), .clr_i(clr), .pdm_clk_o(pdm_clk), .bits_o(bits),
    .ones_o(ones), .idle_o(idle));
  ////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // inputs move a small fixed delay after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wait_mode(input pdmmic_pkg::pdmmic_mode_t m, input int lim);
    int k = 0;
    while (mode !== m && k < lim) begin
      tick(1);
      k++;
    end
  endtask
  task automatic wait_bits(input int n);
    int k = 0;
    while (bits < n && k < 20000) begin
      tick(1);
      k++;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // reset with a strap, then a late strap change must not count
  task automatic t_reset(input logic s);
    run = 1'b0;
    sel = s;
    srst = 1'b1;
    tick(5);
    srst = 1'b0;
    tick(6);
    check("strap", left, s);
    check("mode_rst", mode, pdmmic_pkg::PDMMIC_MODE_SLEEP);
    check("oe_rst", oe, 1'b0);
    sel = ~s;
    tick(4);
    check("strap_late", left, s);
    sel = s;
  endtask
  // asleep nothing pops: fifo takes eight words then refuses
  task automatic t_fill();
    int n = 0;
    adata = 16'h7FFF;
    avalid = 1'b1;
    while (ready === 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check("fifo_words", n, 8);
    check("oe_sleep", oe, 1'b0);
  endtask
  // start the clock, mode follows the band, then settles
  task automatic t_wake(input logic [15:0] h, input pdmmic_pkg::pdmmic_mode_t m);
    half_ns = h;
    run = 1'b1;
    wait_mode(m, 400);
    check("mode_wake", mode, m);
    check("settled_0", settled, 1'b0);
    tick(190);
    check("settled_190", settled, 1'b0);
    tick(20);
    check("settled_210", settled, 1'b1);
  endtask
  // drive starts 30 ns or more after own edge, ends before the next own edge
  task automatic t_slot(input logic lft);
    realtime t0;
    int n;
    repeat (4) begin
      if (lft) @(posedge pdm_clk);
      else @(negedge pdm_clk);
      t0 = $realtime;
      n = 0;
      while (oe !== 1'b1 && n < 10) begin
        @(posedge clk);
        #1;
        n++;
      end
      check("oe_on", oe, 1'b1);
      if (lft) check("en_delay", ($realtime - t0) >= 30.0, 1'b1);
      else check("en_delay", ($realtime - t0) >= 30.0, 1'b1);
      if (lft) @(negedge pdm_clk);
      else @(posedge pdm_clk);
      t0 = $realtime;
      n = 0;
      while (oe !== 1'b0 && n < 10) begin
        @(posedge clk);
        #1;
        n++;
      end
      check("oe_off_slot", oe, 1'b0);
      if (lft) check("release", ($realtime - t0) < half_ns, 1'b1);
      else check("release", ($realtime - t0) < half_ns, 1'b1);
    end
    tick(1);
  endtask
  // full scale gives all ones, negative full scale no ones
  task automatic t_density(input logic [15:0] v);
    adata = v;
    avalid = 1'b1;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    // a loop saturated at the opposite rail needs many bits to unwind
    wait_bits(160);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    wait_bits(64);
    check("bits", bits, 16'h0040);
    check("ones", ones, v[15] ? 16'h0000 : 16'h0040);
    check("idle_hits", idle, 16'h0000);
  endtask
  // moving between active bands switches mode and restarts settling
  task automatic t_switch();
    avalid = 1'b0;
    half_ns = 16'h03E8;
    wait_mode(pdmmic_pkg::PDMMIC_MODE_LP, 400);
    check("mode_lp", mode, pdmmic_pkg::PDMMIC_MODE_LP);
    check("settled_lp", settled, 1'b0);
    check("ready_drain", ready, 1'b1);
    half_ns = 16'h00A0;
    wait_mode(pdmmic_pkg::PDMMIC_MODE_HQ, 400);
    check("mode_hq", mode, pdmmic_pkg::PDMMIC_MODE_HQ);
    check("settled_hq", settled, 1'b0);
  endtask
  // stopped clock: sleep only after the entry delay
  task automatic t_sleep();
    run = 1'b0;
    tick(100);
    check("mode_awake", mode, pdmmic_pkg::PDMMIC_MODE_HQ);
    wait_mode(pdmmic_pkg::PDMMIC_MODE_SLEEP, 300);
    check("mode_sleep", mode, pdmmic_pkg::PDMMIC_MODE_SLEEP);
    tick(2);
    check("oe_off", oe, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    t_reset(1'b1);
    t_fill();
    t_wake(16'h00A0, pdmmic_pkg::PDMMIC_MODE_HQ);
    t_slot(1'b1);
    t_density(16'h7FFF);
    t_density(16'h8000);
    t_switch();
    t_sleep();
    t_reset(1'b0);
    t_wake(16'h03E8, pdmmic_pkg::PDMMIC_MODE_LP);
    t_slot(1'b0);
    t_density(16'h7FFF);
    summarize();
  end
  // hang guard, about three times the expected run
  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
endmodule
